// File: hw/lwpr_config_regs.sv
// What this block does
// - Config write with unsupported feature bit faults and is not stored.
// - Bits 1..6 allow value sample and five counted events.
// - Bit 29 selects continuous mode, else synchronized mode.
// - Bit 30 enables timestamp in records when the counter exists.
// - Bit 31 allows threshold interrupts.
// - Bits 47:40 give the threshold interrupt vector.
// - Bits 39:32 give the core identifier copied into records.
// - Config register resets to zero.
// - Config bits 31:1 are exposed through the capability query.
// - Address read returns held address with no flush.
// - Non-zero register write of the address faults.
// - Writing zero to the address discards state; it stops profiling unless a same-cycle load installs a valid address.
// - Address held is linear; store subtracts the current data segment base.
// - Address register resets to zero.
// - Profiling instructions fault invalid opcode if unsupported or mask bit clear.
// - Insert instruction writes a record each execution while profiling is enabled, unless a value-sample record is due in that cycle and takes its place.
// - Value sample uses its own counter, records once every val_interval+1 samples.
// - Load installs address and enables only for a valid block.
// - Store reports active address or zero when off.
module lwpr_config_regs #(
    parameter logic [63:0] CAPS = lwprof_pkg::CAP_DEFAULT
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        facility_present,
    input  wire logic [63:0] extended_feature_mask,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [31:0] reg_addr,
    input  wire logic [63:0] reg_wdata,
    output logic      [63:0] reg_rdata,
    output logic             reg_ack,
    output logic             general_protection_fault,
    input  wire logic [2:0]  instr_op,
    input  wire logic [63:0] instr_addr,
    input  wire logic [63:0] data_segment_base,
    input  wire logic        block_valid,
    input  wire logic [31:0] val_interval,
    output logic             invalid_opcode_fault,
    output logic      [63:0] instr_result,
    output logic             instr_done,
    output logic             record_write,
    output logic      [7:0]  record_event_id,
    output logic      [7:0]  record_core_id,
    output logic             record_timestamp_en,
    output logic             profiling_enabled,
    output logic             discard_state,
    output logic             continuous_mode,
    output logic             threshold_int_allow,
    output logic      [7:0]  threshold_vector,
    output logic      [5:0]  event_allow,
    output logic      [31:0] capability_query
);
    typedef struct packed {
        logic [63:0] cfg;
        logic [63:0] cbaddr;
        logic [63:0] rdata;
        logic        ack;
        logic        gp;
        logic        ud;
        logic [63:0] result;
        logic        done;
        logic        rec;
        logic [7:0]  rec_id;
        logic        discard;
        logic        en;
    } lwpr_state_t;

    lwpr_state_t s_q;
    lwpr_state_t s_d;
    lwpr_val_if  vif ();

    lwpr_val_counter u_val (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .vif   (vif)
    );

    function automatic logic bad_cfg(input logic [63:0] v);
        bad_cfg = |(v & ~(CAPS & lwprof_pkg::CAP_FEATURE_MASK | lwprof_pkg::CFG_DEFINED_MASK
                  & ~lwprof_pkg::CAP_FEATURE_MASK));
    endfunction

    typedef lwprof_pkg::lwpr_op_t lwpr_op_local_t;

    logic           avail;
    logic           enabled;
    lwpr_op_local_t op;
    // Helpers read only by the assertions below
    logic           reg_idle;
    logic           cfg_wr_ok;

    assign avail   = facility_present && extended_feature_mask[lwprof_pkg::XFM_BIT];
    assign enabled = s_q.en;
    assign op      = lwpr_op_local_t'(instr_op);

    assign reg_idle  = !reg_rd && !reg_wr;
    assign cfg_wr_ok = ce && reg_wr && !reg_rd && reg_addr == lwprof_pkg::CFG_ADDR
                       && !bad_cfg(reg_wdata) && op == lwprof_pkg::LWPR_OP_NONE;

    assign vif.count = val_interval;
    assign vif.load  = ce && avail && op == lwprof_pkg::LWPR_OP_LOAD && block_valid;
    assign vif.dec   = ce && avail && op == lwprof_pkg::LWPR_OP_VALUE && enabled
                       && s_q.cfg[lwprof_pkg::BIT_VALUE];

    always_comb begin
        s_d = s_q;
        s_d.ack     = 1'b0;
        s_d.gp      = 1'b0;
        s_d.ud      = 1'b0;
        s_d.done    = 1'b0;
        s_d.rec     = 1'b0;
        s_d.discard = 1'b0;
        if (reg_rd) begin
            s_d.ack = 1'b1;
            if (reg_addr == lwprof_pkg::CFG_ADDR) begin
                s_d.rdata = s_q.cfg;
            end else if (reg_addr == lwprof_pkg::CBADDR_ADDR) begin
                s_d.rdata = s_q.cbaddr; // No flush side effect
            end else begin
                s_d.rdata = 64'h0000_0000_0000_0000;
                s_d.gp = 1'b1;
            end
        end else if (reg_wr) begin
            s_d.ack = 1'b1;
            if (reg_addr == lwprof_pkg::CFG_ADDR) begin
                if (bad_cfg(reg_wdata)) begin
                    s_d.gp = 1'b1;
                end else begin
                    s_d.cfg = reg_wdata;
                end
            end else if (reg_addr == lwprof_pkg::CBADDR_ADDR) begin
                if (reg_wdata != 64'h0000_0000_0000_0000) begin
                    s_d.gp = 1'b1;
                end else begin
                    s_d.cbaddr = 64'h0000_0000_0000_0000;
                    s_d.discard = 1'b1;
                end
            end else begin
                s_d.gp = 1'b1;
            end
        end
        if (op != lwprof_pkg::LWPR_OP_NONE) begin
            s_d.done = 1'b1;
            if (!avail) begin
                s_d.ud = 1'b1;
            end else begin
                case (op)
                    lwprof_pkg::LWPR_OP_LOAD: begin
                        if (instr_addr == 64'h0000_0000_0000_0000) begin
                            s_d.cbaddr = 64'h0000_0000_0000_0000;
                        end else if (block_valid) begin
                            // Stored linear so later accesses skip the segment base
                            s_d.cbaddr = instr_addr + data_segment_base;
                        end else begin
                            s_d.gp = 1'b1;
                            s_d.cbaddr = 64'h0000_0000_0000_0000;
                        end
                    end
                    lwprof_pkg::LWPR_OP_STORE: begin
                        // Effective address back out; zero when off
                        s_d.result = enabled ? s_q.cbaddr - data_segment_base
                                             : 64'h0000_0000_0000_0000;
                    end
                    lwprof_pkg::LWPR_OP_INSERT: begin
                        if (enabled) begin
                            s_d.rec = 1'b1;
                            s_d.rec_id = 8'hff;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (vif.fire) begin
            s_d.rec = 1'b1;
            s_d.rec_id = 8'h01;
        end
        // Kept as a flop so the enable output does not hang off a 64-bit compare
        s_d.en = s_d.cbaddr != 64'h0000_0000_0000_0000;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q        <= '0;
            s_q.cfg    <= lwprof_pkg::CFG_RESET;
            s_q.cbaddr <= lwprof_pkg::CBADDR_RESET;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign reg_rdata                = s_q.rdata;
    assign reg_ack                  = s_q.ack;
    assign general_protection_fault = s_q.gp;
    assign invalid_opcode_fault     = s_q.ud;
    assign instr_result             = s_q.result;
    assign instr_done               = s_q.done;
    assign record_write             = s_q.rec;
    assign record_event_id          = s_q.rec_id;
    assign record_core_id           = s_q.cfg[lwprof_pkg::CORE_LSB +: 8];
    assign record_timestamp_en      = s_q.cfg[lwprof_pkg::BIT_TIMESTAMP]
                                      && CAPS[lwprof_pkg::BIT_TIMESTAMP];
    assign profiling_enabled        = s_q.en;
    assign discard_state            = s_q.discard;
    assign continuous_mode          = s_q.cfg[lwprof_pkg::BIT_CONTINUOUS];
    assign threshold_int_allow      = s_q.cfg[lwprof_pkg::BIT_INT];
    assign threshold_vector         = s_q.cfg[lwprof_pkg::VEC_LSB +: 8];
    assign event_allow              = s_q.cfg[lwprof_pkg::BIT_REFCLK:lwprof_pkg::BIT_VALUE];
    assign capability_query         = {s_q.cfg[31:1], 1'b0};

    AST_CFG_GP: assert property (@(posedge clock) disable iff (rst)
        ce && reg_wr && !reg_rd && reg_addr == lwprof_pkg::CFG_ADDR && bad_cfg(reg_wdata)
        |=> general_protection_fault && $stable(s_q.cfg))
        else $error("bad config write not faulted");
    AST_CB_GP: assert property (@(posedge clock) disable iff (rst)
        ce && reg_wr && !reg_rd && reg_addr == lwprof_pkg::CBADDR_ADDR && reg_wdata != 64'h0
        && op == lwprof_pkg::LWPR_OP_NONE |=> general_protection_fault && $stable(s_q.cbaddr))
        else $error("nonzero address write not faulted");
    AST_CB_ZERO: assert property (@(posedge clock) disable iff (rst)
        ce && reg_wr && !reg_rd && reg_addr == lwprof_pkg::CBADDR_ADDR && reg_wdata == 64'h0
        && op == lwprof_pkg::LWPR_OP_NONE |=> !profiling_enabled && discard_state)
        else $error("zero write did not stop");
    AST_UD: assert property (@(posedge clock) disable iff (rst)
        ce && !avail && op != lwprof_pkg::LWPR_OP_NONE |=> invalid_opcode_fault)
        else $error("missing invalid opcode fault");
    AST_RESERVED: assert property (@(posedge clock) disable iff (rst)
        (s_q.cfg & ~lwprof_pkg::CFG_DEFINED_MASK) == 64'h0)
        else $error("reserved config bit set");
    AST_CAPQ: assert property (@(posedge clock) disable iff (rst)
        capability_query[31:1] == s_q.cfg[31:1] && !capability_query[0])
        else $error("capability query mismatch");
    AST_INSERT: assert property (@(posedge clock) disable iff (rst)
        ce && avail && enabled && op == lwprof_pkg::LWPR_OP_INSERT |=> record_write)
        else $error("insert wrote no record");
    AST_STORE: assert property (@(posedge clock) disable iff (rst)
        ce && avail && !enabled && op == lwprof_pkg::LWPR_OP_STORE |=> instr_result == 64'h0)
        else $error("store while off not zero");
    AST_LOAD_BAD: assert property (@(posedge clock) disable iff (rst)
        ce && avail && op == lwprof_pkg::LWPR_OP_LOAD && !block_valid |=> !profiling_enabled)
        else $error("invalid block enabled profiling");

    // Only feature bits covered by the capability parameter may ever be held
    AST_CAP_ONLY: assert property (@(posedge clock) disable iff (rst)
        (s_q.cfg & lwprof_pkg::CAP_FEATURE_MASK & ~CAPS) == 64'h0000_0000_0000_0000)
        else $error("unsupported feature bit held");
    AST_CFG_STORE: assert property (@(posedge clock) disable iff (rst)
        cfg_wr_ok |=> s_q.cfg == $past(reg_wdata) && !general_protection_fault)
        else $error("good config write not stored");
    AST_ACK: assert property (@(posedge clock) disable iff (rst)
        ce && (reg_rd || reg_wr) |=> reg_ack)
        else $error("register access not acknowledged");
    AST_VALUE_GATE: assert property (@(posedge clock) disable iff (rst)
        ce && op == lwprof_pkg::LWPR_OP_VALUE && !s_q.cfg[lwprof_pkg::BIT_VALUE] |-> !vif.dec)
        else $error("value sample counted while not allowed");
    AST_CONTINUOUS_MODE_ENABLE: assert property (@(posedge clock) disable iff (rst)
        cfg_wr_ok && !reg_wdata[lwprof_pkg::BIT_CONTINUOUS] |=> !continuous_mode)
        else $error("continuous mode without its bit");
    AST_TS: assert property (@(posedge clock) disable iff (rst)
        record_timestamp_en |-> CAPS[lwprof_pkg::BIT_TIMESTAMP])
        else $error("timestamp enabled without counter");
    AST_INT_CAP: assert property (@(posedge clock) disable iff (rst)
        threshold_int_allow |-> CAPS[lwprof_pkg::BIT_INT])
        else $error("threshold interrupt allowed though unsupported");
    AST_VEC: assert property (@(posedge clock) disable iff (rst)
        cfg_wr_ok |=> threshold_vector == $past(reg_wdata[lwprof_pkg::VEC_LSB +: 8]))
        else $error("vector not taken from config");
    AST_CORE: assert property (@(posedge clock) disable iff (rst)
        cfg_wr_ok |=> record_core_id == $past(reg_wdata[lwprof_pkg::CORE_LSB +: 8]))
        else $error("core id not taken from config");

    // Reset checks must not be disabled by the reset they watch
    AST_RST_CFG: assert property (@(posedge clock)
        rst |=> s_q.cfg == lwprof_pkg::CFG_RESET)
        else $error("config not cleared by reset");
    AST_RST_CB: assert property (@(posedge clock)
        rst |=> s_q.cbaddr == lwprof_pkg::CBADDR_RESET && !profiling_enabled)
        else $error("address not cleared by reset");

    AST_CB_READ: assert property (@(posedge clock) disable iff (rst)
        ce && reg_rd && reg_addr == lwprof_pkg::CBADDR_ADDR && op == lwprof_pkg::LWPR_OP_NONE
        |=> reg_rdata == $past(s_q.cbaddr) && !discard_state && $stable(s_q.cbaddr))
        else $error("address read disturbed state");
    AST_EN_COPY: assert property (@(posedge clock) disable iff (rst)
        profiling_enabled == (s_q.cbaddr != 64'h0000_0000_0000_0000))
        else $error("enable flag out of step with address");
    AST_LOAD_OK: assert property (@(posedge clock) disable iff (rst)
        ce && avail && op == lwprof_pkg::LWPR_OP_LOAD && block_valid && reg_idle
        && instr_addr != 64'h0 |=> profiling_enabled && !general_protection_fault)
        else $error("valid block not loaded");
    // Segment base is folded in once at load; store subtracts the current base afterwards
    AST_LINEAR: assert property (@(posedge clock) disable iff (rst)
        ce && avail && op == lwprof_pkg::LWPR_OP_LOAD && block_valid && reg_idle
        && instr_addr != 64'h0 |=> s_q.cbaddr == $past(instr_addr + data_segment_base))
        else $error("address not stored linear");
    AST_UD_KEEP: assert property (@(posedge clock) disable iff (rst)
        ce && !avail && op != lwprof_pkg::LWPR_OP_NONE && reg_idle
        |=> $stable(s_q.cbaddr) && $stable(instr_result))
        else $error("faulted instruction changed state");
    AST_DONE: assert property (@(posedge clock) disable iff (rst)
        ce && op != lwprof_pkg::LWPR_OP_NONE |=> instr_done)
        else $error("instruction not completed");
    AST_INSERT_ID: assert property (@(posedge clock) disable iff (rst)
        ce && avail && enabled && op == lwprof_pkg::LWPR_OP_INSERT && !vif.fire
        |=> record_event_id == 8'hff)
        else $error("insert record carries wrong id");
    AST_VALUE_REC: assert property (@(posedge clock) disable iff (rst)
        ce && vif.fire |=> record_write && record_event_id == 8'h01)
        else $error("value sample record missing");
    AST_FIRE_SRC: assert property (@(posedge clock) disable iff (rst)
        ce && !vif.dec && !vif.load |=> !vif.fire)
        else $error("value record without a decrement");
    AST_STORE_ON: assert property (@(posedge clock) disable iff (rst)
        ce && avail && enabled && op == lwprof_pkg::LWPR_OP_STORE
        |=> instr_result == $past(s_q.cbaddr - data_segment_base))
        else $error("store returned wrong address");

    COV_LOAD: cover property (@(posedge clock) disable iff (rst)
        ce && avail && op == lwprof_pkg::LWPR_OP_LOAD && block_valid ##1 profiling_enabled);
    COV_VALUE: cover property (@(posedge clock) disable iff (rst) vif.fire);
    COV_STOP: cover property (@(posedge clock) disable iff (rst) profiling_enabled ##1 discard_state);
    COV_INSERT: cover property (@(posedge clock) disable iff (rst)
        record_write && record_event_id == 8'hff);
    COV_REFUSED: cover property (@(posedge clock) disable iff (rst) general_protection_fault);
endmodule

// File: shared/lwprof_pkg.sv
package lwprof_pkg;
    localparam logic [31:0] CFG_ADDR         = 32'hc000_0105;
    localparam logic [31:0] CBADDR_ADDR      = 32'hc000_0106;
    localparam logic [63:0] CFG_RESET        = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CBADDR_RESET     = 64'h0000_0000_0000_0000;
    localparam int          BIT_VALUE        = 1;
    localparam int          BIT_RET_INSTR    = 2;
    localparam int          BIT_RET_BRANCH   = 3;
    localparam int          BIT_DC_MISS      = 4;
    localparam int          BIT_CLK          = 5;
    localparam int          BIT_REFCLK       = 6;
    localparam int          BIT_CONTINUOUS   = 29;
    localparam int          BIT_TIMESTAMP    = 30;
    localparam int          BIT_INT          = 31;
    localparam int          CORE_LSB         = 32;
    localparam int          VEC_LSB          = 40;
    localparam int          XFM_BIT          = 62;
    localparam logic [63:0] CFG_DEFINED_MASK = 64'h0000_ffff_e000_007e;
    localparam logic [63:0] CAP_FEATURE_MASK = 64'h0000_0000_e000_007e;
    localparam logic [63:0] CAP_DEFAULT      = 64'h0000_0000_e000_007e;

    typedef enum logic [2:0] {
        LWPR_OP_NONE,
        LWPR_OP_LOAD,
        LWPR_OP_STORE,
        LWPR_OP_INSERT,
        LWPR_OP_VALUE
    } lwpr_op_t;
endpackage

// File: shared/lwpr_val_if.sv
interface lwpr_val_if;
    logic        load;
    logic [31:0] count;
    logic        dec;
    logic        fire;
    logic [31:0] counter;
    modport ctl (output load, output count, output dec, input fire, input counter);
    modport cnt (input load, input count, input dec, output fire, output counter);
endinterface

// File: hw/lwpr_val_counter.sv
module lwpr_val_counter (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic ce,
    lwpr_val_if.cnt   vif
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        fire;
    } lwpr_cnt_state_t;

    lwpr_cnt_state_t s_q;
    lwpr_cnt_state_t s_d;
    logic [31:0]     nxt;

    always_comb begin
        s_d = s_q;
        nxt = s_q.cnt - 32'h0000_0001;
        s_d.fire = 1'b0;
        if (vif.load) begin
            s_d.cnt = vif.count;
        end else if (vif.dec) begin
            // Record only when the counter goes negative
            if (nxt[31]) begin
                s_d.fire = 1'b1;
                s_d.cnt = vif.count;
            end else begin
                s_d.cnt = nxt;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign vif.fire    = s_q.fire;
    assign vif.counter = s_q.cnt;
endmodule

// File: dv/lwpr_config_regs_tb.sv
module lwpr_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        ce, facility_present, reg_rd, reg_wr, block_valid;
    logic [63:0] extended_feature_mask, reg_wdata, instr_addr, data_segment_base;
    logic [31:0] reg_addr, val_interval;
    logic [2:0]  instr_op;
    logic [63:0] reg_rdata, instr_result;
    logic        reg_ack, general_protection_fault, invalid_opcode_fault, instr_done;
    logic        record_write, record_timestamp_en, profiling_enabled, discard_state;
    logic        continuous_mode, threshold_int_allow;
    logic [7:0]  record_event_id, record_core_id, threshold_vector, last_id;
    logic [5:0]  event_allow;
    logic [31:0] capability_query;
    logic [63:0] q;
    logic        gp, ud;
    int          checks, mismatches, nrec, ndisc, n0;

    localparam logic [63:0] FULL = 64'h0000_abcd_e000_007e;
    localparam logic [63:0] BAD[5] = '{64'h0000_0000_0000_0001, 64'h0000_0000_0000_0080,
        64'h0000_0000_1000_0000, 64'h0001_0000_0000_0000, 64'h8000_0000_0000_0000};

    lwpr_config_regs uut (.clock, .rst, .ce, .facility_present, .extended_feature_mask,
        .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .general_protection_fault,
        .instr_op, .instr_addr, .data_segment_base, .block_valid, .val_interval,
        .invalid_opcode_fault,
        .instr_result, .instr_done, .record_write, .record_event_id, .record_core_id,
        .record_timestamp_en, .profiling_enabled, .discard_state, .continuous_mode,
        .threshold_int_allow, .threshold_vector, .event_allow, .capability_query);

    always #20 clock = ~clock;

    // Pulses last a cycle; tallied at the falling edge, away from the edge that sets them
    always @(negedge clock) begin
        if (record_write === 1'b1) begin
            nrec++;
            last_id = record_event_id;
        end
        if (discard_state === 1'b1) ndisc++;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Request was raised at a falling edge; drop it one cycle later, then look for the answer
    task automatic wait_ans();
        int i;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        instr_op = 3'h0;
        for (i = 0; i < 3; i++) begin
            if ((reg_ack | instr_done | general_protection_fault | invalid_opcode_fault) === 1'b1)
                break;
            @(negedge clock);
        end
        gp = general_protection_fault;
        ud = invalid_opcode_fault;
        q = reg_rdata;
        if (i == 3) chk(1'b0, 1'b1, "no answer");
        @(negedge clock);
    endtask

    task automatic acc(input logic wr, input logic [31:0] a, input logic [63:0] d);
        reg_wr = wr;
        reg_rd = ~wr;
        reg_addr = a;
        reg_wdata = d;
        wait_ans();
    endtask

    task automatic run_op(input lwprof_pkg::lwpr_op_t op, input logic [63:0] a);
        instr_op = op;
        instr_addr = a;
        wait_ans();
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        give_verdict();
    end

    initial begin
        ce = 1'b1;
        facility_present = 1'b1;
        {reg_rd, reg_wr, block_valid, instr_op} = '0;
        {extended_feature_mask, reg_wdata, instr_addr, data_segment_base, reg_addr} = '0;
        val_interval = 32'h0000_0002;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        acc(1'b0, lwprof_pkg::CFG_ADDR, '0);
        chk(q, lwprof_pkg::CFG_RESET, "cfg reset");
        acc(1'b0, lwprof_pkg::CBADDR_ADDR, '0);
        chk(q, lwprof_pkg::CBADDR_RESET, "cbaddr reset");
        chk(profiling_enabled, 1'b0, "off at reset");
        acc(1'b1, lwprof_pkg::CFG_ADDR, 64'h0000_0000_2000_0000);
        chk(continuous_mode, 1'b1, "continuous");
        foreach (BAD[k]) begin
            acc(1'b1, lwprof_pkg::CFG_ADDR, BAD[k] | 64'h0000_0000_2000_0000);
            chk(gp, 1'b1, "reserved set");
        end
        acc(1'b0, lwprof_pkg::CFG_ADDR, '0);
        chk(q, 64'h0000_0000_2000_0000, "refused writes not stored");
        for (int i = 1; i <= 6; i++) begin
            acc(1'b1, lwprof_pkg::CFG_ADDR, 64'h0000_0000_0000_0001 << i);
            chk(event_allow, 6'h01 << (i - 1), "one allow bit");
            chk(continuous_mode, 1'b0, "synchronized");
        end
        acc(1'b1, lwprof_pkg::CFG_ADDR, FULL);
        acc(1'b0, lwprof_pkg::CFG_ADDR, '0);
        chk(q, FULL, "cfg readback");
        chk(threshold_vector, 8'hab, "vector");
        chk(record_core_id, 8'hcd, "core id");
        chk(threshold_int_allow, 1'b1, "int allow");
        chk(record_timestamp_en, 1'b1, "timestamp");
        chk(capability_query, 32'he000_007e, "query");
        acc(1'b1, 32'hc000_0107, 64'h0000_0000_0000_0001);
        chk(gp, 1'b1, "unmapped");
        // Every op refused first with the mask bit clear, then with the facility absent
        for (int p = 0; p < 2; p++) begin
            for (int o = 1; o <= 4; o++) begin
                run_op(lwprof_pkg::lwpr_op_t'(o), 64'h0000_0000_0000_2040);
                chk(ud, 1'b1, "op while unavailable");
            end
            extended_feature_mask = 64'h4000_0000_0000_0000;
            facility_present = 1'b0;
        end
        facility_present = 1'b1;
        run_op(lwprof_pkg::LWPR_OP_LOAD, 64'h0000_0000_0000_2040);
        chk(profiling_enabled, 1'b0, "bad block");
        data_segment_base = 64'h0000_0000_0001_0000;
        block_valid = 1'b1;
        run_op(lwprof_pkg::LWPR_OP_LOAD, 64'h0000_0000_0000_2040);
        chk(profiling_enabled, 1'b1, "load");
        n0 = ndisc;
        acc(1'b0, lwprof_pkg::CBADDR_ADDR, '0);
        chk(q, 64'h0000_0000_0001_2040, "linear addr");
        chk(64'(ndisc - n0), 64'h0000_0000_0000_0000, "read disturbs nothing");
        data_segment_base = 64'h0000_0000_0000_2000;
        run_op(lwprof_pkg::LWPR_OP_STORE, '0);
        chk(instr_result, 64'h0000_0000_0001_0040, "store addr");
        n0 = nrec;
        run_op(lwprof_pkg::LWPR_OP_INSERT, '0);
        run_op(lwprof_pkg::LWPR_OP_INSERT, '0);
        repeat (3) @(negedge clock);
        chk(64'(nrec - n0), 64'h0000_0000_0000_0002, "inserts");
        chk(last_id, 8'hff, "insert id");
        // Interval 2: three records in nine samples whatever the counter's start value
        n0 = nrec;
        repeat (9) run_op(lwprof_pkg::LWPR_OP_VALUE, '0);
        repeat (3) @(negedge clock);
        chk(64'(nrec - n0), 64'h0000_0000_0000_0003, "value interval");
        chk(last_id, 8'h01, "value id");
        acc(1'b1, lwprof_pkg::CFG_ADDR, FULL & ~64'h0000_0000_0000_0002);
        n0 = nrec;
        repeat (3) run_op(lwprof_pkg::LWPR_OP_VALUE, '0);
        repeat (3) @(negedge clock);
        chk(64'(nrec - n0), 64'h0000_0000_0000_0000, "value not allowed");
        // A write offered while the clock enable is low must never be taken
        ce = 1'b0;
        reg_wr = 1'b1;
        reg_addr = lwprof_pkg::CFG_ADDR;
        reg_wdata = '0;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
        ce = 1'b1;
        @(negedge clock);
        chk(reg_ack, 1'b0, "no ack while frozen");
        chk(continuous_mode, 1'b1, "config kept while frozen");
        acc(1'b1, lwprof_pkg::CBADDR_ADDR, 64'h0000_0000_0000_4000);
        chk(gp, 1'b1, "nonzero addr write");
        chk(profiling_enabled, 1'b1, "still on");
        n0 = ndisc;
        acc(1'b1, lwprof_pkg::CBADDR_ADDR, '0);
        chk(gp, 1'b0, "zero write accepted");
        chk(profiling_enabled, 1'b0, "stopped");
        chk(64'(ndisc - n0), 64'h0000_0000_0000_0001, "discard");
        run_op(lwprof_pkg::LWPR_OP_STORE, '0);
        chk(instr_result, 64'h0000_0000_0000_0000, "store when off");
        give_verdict();
    end
endmodule
